// ==== verilog/awo_ctrl.sv ====
// watchdog flags, channel enables, input mode control and offset trim register bank
// Function
// - eight sticky watchdog event flags for channels 0 to 7
// - flags set only by hardware; writing 0 clears, writing 1 keeps
// - flags and enables act only in buffered continuous or scan mode
// - two enable bits for channels 8 and 9
// - eight enable bits for channels 0 to 7
// - enables read/write; hardware may set, software clears with 0
// - control bit 0 shorts positive and negative inputs for calibration
// - control bit 1 selects internal delay per converter clock speed
// - offset bits 5:0 two's complement, 0 to 31 positive
// - code 100000 reserved; 100001 to 111111 give -31 to -1
// - two sticky flags for channels 8 and 9, cleared like low flags
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module awo_ctrl #(
  parameter int NUM_CH = awo_pkg::NUM_CH,
  parameter int RES_W = awo_pkg::RES_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic conv_valid,
  input wire logic [3:0] conv_channel,
  input wire logic [RES_W-1:0] conv_result,
  input wire logic [RES_W-1:0] thr_high,
  input wire logic [RES_W-1:0] thr_low,
  input wire logic [1:0] conv_mode,
  input wire logic [NUM_CH-1:0] hw_enable_set,
  output logic input_short_calibration,
  output logic delay_time_select,
  output logic differential_select,
  output logic signed [6:0] offset_correction,
  output logic mode_conflict,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [NUM_CH-1:0] flag_reg, flag_next;
  logic [NUM_CH-1:0] en_reg, en_next;
  logic [awo_pkg::CTRL_W-1:0] ctrl_reg;
  logic [awo_pkg::TRIM_W-1:0] trim_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] status_reg, status_next;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic conflict_reg;
  logic signed [6:0] corr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire sel_fh = bus_addr == awo_pkg::OFF_FLAG_HIGH;
  wire sel_fl = bus_addr == awo_pkg::OFF_FLAG_LOW;
  wire sel_eh = bus_addr == awo_pkg::OFF_EN_HIGH;
  wire sel_el = bus_addr == awo_pkg::OFF_EN_LOW;
  wire sel_ct = bus_addr == awo_pkg::OFF_CTRL;
  wire sel_tr = bus_addr == awo_pkg::OFF_TRIM;
  wire sel_mk = bus_addr == awo_pkg::OFF_IRQ_MASK;
  wire sel_st = bus_addr == awo_pkg::OFF_STATUS;
  wire wr_fh = bus_wr && sel_fh;
  wire wr_fl = bus_wr && sel_fl;
  wire wr_eh = bus_wr && sel_eh;
  wire wr_el = bus_wr && sel_el;

  // watchdog is only live in buffered continuous and scan modes
  wire mode_live = (conv_mode == awo_pkg::AWO_MODE_BUF_CONT) ||
                   (conv_mode == awo_pkg::AWO_MODE_SCAN);
  wire scan_mode = conv_mode == awo_pkg::AWO_MODE_SCAN;
  wire cont_mode = conv_mode == awo_pkg::AWO_MODE_BUF_CONT;

  ////////////////////////////////////////////////////////////////////////////
  // window compare on the incoming result
  wire outside;
  awo_window_cmp #(
    .RES_W(RES_W)
  ) awo_window_cmp_inst (
    .result(conv_result),
    .thr_high(thr_high),
    .thr_low(thr_low),
    .outside(outside)
  );

  wire [NUM_CH-1:0] hit;
  wire [NUM_CH-1:0] wmask;
  wire [NUM_CH-1:0] ewmask;
  // per-channel set and software write masks
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign hit[g] = conv_valid && mode_live && outside && en_reg[g] &&
                      (conv_channel == 4'(g));
      // flags: a written 0 clears, a written 1 is ignored
      if (g < awo_pkg::LOW_CH) begin : g_lo
        assign wmask[g] = wr_fl && !bus_wdata[g];
        assign ewmask[g] = wr_el;
      end else begin : g_hi
        assign wmask[g] = wr_fh && !bus_wdata[g-awo_pkg::LOW_CH];
        assign ewmask[g] = wr_eh;
      end
    end
  endgenerate

  wire [NUM_CH-1:0] en_wdata = {bus_wdata[awo_pkg::HIGH_CH-1:0], bus_wdata[7:0]};

  // set wins over clear so an event in the clearing cycle survives
  assign flag_next = (flag_reg & ~wmask) | hit;
  // hardware set also wins over a software write of 0
  assign en_next = ((en_reg & ~ewmask) | (en_wdata & ewmask)) | hw_enable_set;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: bit 0 any watchdog hit, bit 1 differential select in scan or buffered continuous mode
  wire conflict_now = ctrl_reg[awo_pkg::BIT_DIFF] && (scan_mode || cont_mode);
  wire [1:0] st_ev = {conflict_now, |hit};
  wire [1:0] st_clr = (bus_wr && sel_st) ? bus_wdata[1:0] : 2'h0;
  assign status_next = (status_reg & ~st_clr) | st_ev;

  // offset code as a signed LSB correction; the reserved code applies none
  wire [5:0] trim_code = trim_reg;
  wire signed [6:0] corr_next = (trim_code == awo_pkg::TRIM_RESERVED) ? 7'sd0 :
                                {trim_code[5], trim_code};

  ////////////////////////////////////////////////////////////////////////////
  // read mux, unmapped addresses read zero
  wire [31:0] rd_mux =
      sel_fh ? {30'h0, flag_reg[NUM_CH-1:awo_pkg::LOW_CH]} :
      sel_fl ? {24'h0, flag_reg[7:0]} :
      sel_eh ? {30'h0, en_reg[NUM_CH-1:awo_pkg::LOW_CH]} :
      sel_el ? {24'h0, en_reg[7:0]} :
      sel_ct ? {29'h0, ctrl_reg} :
      sel_tr ? {26'h0, trim_reg} :
      sel_mk ? {30'h0, irq_mask_reg} :
      sel_st ? {30'h0, status_reg} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= awo_pkg::FLAG_RESET;
      en_reg <= awo_pkg::EN_RESET;
      status_reg <= 2'h0;
    end else begin
      flag_reg <= flag_next;
      en_reg <= en_next;
      status_reg <= status_next;
    end
  end

  // software configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= awo_pkg::CTRL_RESET;
      trim_reg <= awo_pkg::TRIM_RESET;
      irq_mask_reg <= 2'h0;
    end else begin
      if (bus_wr && sel_ct) begin
        ctrl_reg <= bus_wdata[awo_pkg::CTRL_W-1:0];
      end
      if (bus_wr && sel_tr) begin
        trim_reg <= bus_wdata[awo_pkg::TRIM_W-1:0];
      end
      if (bus_wr && sel_mk) begin
        irq_mask_reg <= bus_wdata[1:0];
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0;
      irq_reg <= 1'b0;
      conflict_reg <= 1'b0;
      corr_reg <= 7'sd0;
    end else begin
      rdata_reg <= bus_rd ? rd_mux : 32'h0;
      irq_reg <= |(status_next & irq_mask_reg);
      conflict_reg <= conflict_now;
      corr_reg <= corr_next;
    end
  end

  assign bus_rdata = rdata_reg;
  assign irq = irq_reg;
  assign mode_conflict = conflict_reg;
  assign offset_correction = corr_reg;
  // control bits go straight from their flip-flops to the analog front end
  assign input_short_calibration = ctrl_reg[awo_pkg::BIT_SHORT];
  assign delay_time_select = ctrl_reg[awo_pkg::BIT_DELAY];
  assign differential_select = ctrl_reg[awo_pkg::BIT_DIFF];

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // flag set and clear
  a_flag_set_hit: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (|hit) |=> ((flag_reg & $past(hit)) == $past(hit)))
    else $error("hit did not set its flag");
  a_flag_no_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!mode_live && !(bus_wr && sel_fl)) |=> (flag_reg[7:0] == $past(flag_reg[7:0])))
    else $error("low flags changed outside live modes");
  a_flag_one_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_fl |=> ((flag_reg[7:0] & $past(bus_wdata[7:0]) & $past(flag_reg[7:0])) ==
                 ($past(bus_wdata[7:0]) & $past(flag_reg[7:0]))))
    else $error("writing ones cleared a flag");
  a_flag_zero_clr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_fl && !(|hit)) |=> ((flag_reg[7:0] & ~$past(bus_wdata[7:0])) == 8'h00))
    else $error("writing zero did not clear low flags");
  a_flag_high_clr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_fh && (bus_wdata[1:0] == 2'h0) && !(|hit)) |=> (flag_reg[9:8] == 2'h0))
    else $error("writing zero did not clear high flags");
  // enable, control and trim writes, and control readback
  a_enable_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_el && !(|hw_enable_set)) |=> (en_reg[7:0] == $past(bus_wdata[7:0])))
    else $error("low enable write lost");
  a_enable_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_eh && !(|hw_enable_set)) |=> (en_reg[9:8] == $past(bus_wdata[1:0])))
    else $error("high enable write lost");
  a_enable_hwset: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (|hw_enable_set) |=> ((en_reg & $past(hw_enable_set)) == $past(hw_enable_set)))
    else $error("hardware enable set lost");
  a_ctrl_outputs: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (bus_wr && sel_ct) |=> ({differential_select, delay_time_select,
       input_short_calibration} == $past(bus_wdata[2:0])))
    else $error("control bits not driven from write");
  a_trim_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (bus_wr && sel_tr) |=> ##1 (offset_correction ==
       (($past(bus_wdata[5:0], 2) == 6'h20) ? 7'sd0 :
        $signed({$past(bus_wdata[5], 2), $past(bus_wdata[5:0], 2)}))))
    else $error("offset correction mismatch");
  a_trim_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (trim_reg == awo_pkg::TRIM_RESERVED) |=> (offset_correction == 7'sd0))
    else $error("reserved offset code applied a correction");
  a_read_latency: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (bus_rd && sel_ct) |=> (bus_rdata == {29'h0, $past(ctrl_reg)}))
    else $error("control readback wrong");

  // read data carries the addressed register in the cycle after the strobe
  a_read_flags_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (bus_rd && sel_fl) |=> (bus_rdata == {24'h0, $past(flag_reg[7:0])}))
    else $error("low flag readback wrong");
  a_read_flags_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (bus_rd && sel_fh) |=> (bus_rdata == {30'h0, $past(flag_reg[9:8])}))
    else $error("high flag readback wrong");
  a_read_en_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (bus_rd && sel_el) |=> (bus_rdata == {24'h0, $past(en_reg[7:0])}))
    else $error("low enable readback wrong");
  a_read_en_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (bus_rd && sel_eh) |=> (bus_rdata == {30'h0, $past(en_reg[9:8])}))
    else $error("high enable readback wrong");
  a_read_trim: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (bus_rd && sel_tr) |=> (bus_rdata == {26'h0, $past(trim_reg)}))
    else $error("offset readback wrong");

  // software can never raise a flag; only a hit does
  a_flag_hw_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ((flag_reg & ~$past(flag_reg) & ~$past(hit)) == '0))
    else $error("flag rose without a hit");
  a_flag_high_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_fh |=> ((flag_reg[9:8] & $past(bus_wdata[1:0]) & $past(flag_reg[9:8])) ==
                 ($past(bus_wdata[1:0]) & $past(flag_reg[9:8]))))
    else $error("writing ones cleared a high flag");

  // configuration holds unless written, or for enables set by hardware
  a_en_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!wr_el && !wr_eh && !(|hw_enable_set)) |=> (en_reg == $past(en_reg)))
    else $error("enable changed without a cause");
  a_ctrl_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !(bus_wr && sel_ct) |=> $stable({differential_select, delay_time_select,
                                       input_short_calibration}))
    else $error("control bits moved without a write");
  a_trim_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !(bus_wr && sel_tr) |=> (trim_reg == $past(trim_reg)))
    else $error("offset code moved without a write");

  // interrupt follows status and mask; a fresh mask shows one cycle late
  a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !($past(bus_wr) && $past(sel_mk)) |-> (irq == |(status_reg & irq_mask_reg)))
    else $error("interrupt level disagrees with status");
  a_hit_status: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (|hit) |=> status_reg[0])
    else $error("hit did not set status");
  a_status_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (bus_wr && sel_st && bus_wdata[0] && !(|hit)) |=> !status_reg[0])
    else $error("status not cleared by writing one");
  a_conflict_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (mode_conflict == ($past(differential_select) && ($past(scan_mode) || $past(cont_mode)))))
    else $error("mode conflict output wrong");

  // offset sign: positive codes pass unchanged, negative ones stay in -31..-1
  a_corr_positive: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !trim_reg[5] |=> (offset_correction == $signed({1'b0, $past(trim_reg)})))
    else $error("positive offset correction wrong");
  a_corr_negative: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (trim_reg[5] && (trim_reg != awo_pkg::TRIM_RESERVED)) |=>
      ((offset_correction < 7'sd0) && (offset_correction >= -7'sd31)))
    else $error("negative offset correction out of range");
endmodule : awo_ctrl
`default_nettype wire

// ==== pkg/awo_pkg.sv ====
// package with register map, field layout and reset values of the watchdog/offset control
package awo_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_FLAG_HIGH = 8'hb0;
  localparam logic [7:0] OFF_FLAG_LOW = 8'hb4;
  localparam logic [7:0] OFF_EN_HIGH = 8'hb8;
  localparam logic [7:0] OFF_EN_LOW = 8'hbc;
  localparam logic [7:0] OFF_CTRL = 8'hc0;
  localparam logic [7:0] OFF_TRIM = 8'hc4;
  localparam logic [7:0] OFF_IRQ_MASK = 8'hc8;
  localparam logic [7:0] OFF_STATUS = 8'hcc;
  localparam int NUM_CH = 10;
  localparam int LOW_CH = 8;
  localparam int HIGH_CH = 2;
  localparam int RES_W = 12;
  localparam int BIT_SHORT = 0;
  localparam int BIT_DELAY = 1;
  localparam int BIT_DIFF = 2;
  localparam int CTRL_W = 3;
  localparam int TRIM_W = 6;
  localparam logic [5:0] TRIM_RESERVED = 6'h20;
  localparam logic [9:0] FLAG_RESET = 10'h000;
  localparam logic [9:0] EN_RESET = 10'h000;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [5:0] TRIM_RESET = 6'h00;
  // conversion modes reported by the core
  typedef enum logic [1:0] {
    AWO_MODE_SINGLE = 2'h0,
    AWO_MODE_NOBUF = 2'h1,
    AWO_MODE_BUF_CONT = 2'h2,
    AWO_MODE_SCAN = 2'h3
  } awo_mode_t;
endpackage : awo_pkg

// ==== verilog/awo_window_cmp.sv ====
// window comparator for one conversion result against high and low thresholds
`timescale 1ns/1ps
`default_nettype none
module awo_window_cmp #(
  parameter int RES_W = 12
) (
  input wire logic [RES_W-1:0] result,
  input wire logic [RES_W-1:0] thr_high,
  input wire logic [RES_W-1:0] thr_low,
  output logic outside
);
  // strict compare: a result equal to a threshold is still inside the window
  assign outside = (result > thr_high) || (result < thr_low);
endmodule : awo_window_cmp
`default_nettype wire

// ==== tb/awo_ctrl_tb.sv ====
// self-checking bench for the watchdog flag, enable, control and offset trim registers
`timescale 1ns/1ps
`default_nettype none
module awo_ctrl_tb;
  logic clk_sys, rst_n, bus_wr, bus_rd, conv_valid, irq, mode_conflict;
  logic input_short_calibration, delay_time_select, differential_select;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata;
  logic [3:0] conv_channel;
  logic [awo_pkg::RES_W-1:0] conv_result, thr_high, thr_low;
  logic [1:0] conv_mode;
  logic [9:0] hw_enable_set;
  logic signed [6:0] offset_correction;
  wire [2:0] ctrl_pins = {differential_select, delay_time_select, input_short_calibration};
  int mismatches, checks_done;
  logic [7:0] offs [8] = '{8'hb0, 8'hb4, 8'hb8, 8'hbc, 8'hc0, 8'hc4, 8'hc8, 8'hcc};
  logic [5:0] codes [6] = '{6'h00, 6'h01, 6'h1f, 6'h20, 6'h21, 6'h3f};
  logic [6:0] corr [6] = '{7'h00, 7'h01, 7'h1f, 7'h00, 7'h61, 7'h7f};
  ////////////////////////////////////////////////////////////////////////////////
  awo_ctrl awo_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_result(conv_result),
    .thr_high(thr_high), .thr_low(thr_low), .conv_mode(conv_mode),
    .hw_enable_set(hw_enable_set), .input_short_calibration(input_short_calibration),
    .delay_time_select(delay_time_select), .differential_select(differential_select),
    .offset_correction(offset_correction), .mode_conflict(mode_conflict), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count; x on a design output never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle write strobe; an edge passes before the next strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the read edge, so sample there
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask : rd
  // one conversion result from the core; mode is left standing as a level
  task automatic conv(input logic [1:0] m, input logic [3:0] ch, input logic [11:0] r);
    @(posedge clk_sys);
    conv_mode <= m;
    conv_valid <= 1'b1;
    conv_channel <= ch;
    conv_result <= r;
    @(posedge clk_sys);
    conv_valid <= 1'b0;
  endtask : conv
  // counts and verdict, shared by the main sequence and the watchdog
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // the tests need well under a thousand cycles; five thousand means a hang
  initial begin
    #(100 * 5000);
    mismatches++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {rst_n, bus_wr, bus_rd, conv_valid, bus_addr, bus_wdata, conv_channel} = '0;
    {conv_result, conv_mode, hw_enable_set} = '0;
    thr_high = 12'h800;
    thr_low = 12'h100;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (offs[i]) rd(offs[i], 32'h0);
    rd(8'h00, 32'h0);
    wr(8'hbc, 32'hffffffff);
    rd(8'hbc, 32'h000000ff);
    wr(8'hb8, 32'hffffffff);
    rd(8'hb8, 32'h00000003);
    for (int i = 0; i < 3; i++) begin
      wr(8'hc0, 32'h1 << i);
      rd(8'hc0, 32'h1 << i);
      chk(ctrl_pins, 32'h1 << i);
    end
    wr(8'hc0, 32'h0);
    foreach (codes[i]) begin
      wr(8'hc4, {26'h0, codes[i]});
      rd(8'hc4, {26'h0, codes[i]});
      chk({25'h0, offset_correction}, {25'h0, corr[i]});
    end
    // only buffered continuous and scan modes raise flags; equal is not outside
    for (int m = 0; m < 4; m++) conv(m[1:0], m[3:0], 12'hfff);
    conv(2'h3, 4'h4, 12'h800);
    conv(2'h3, 4'h5, 12'h100);
    conv(2'h2, 4'h9, 12'h0ff);
    conv(2'h3, 4'ha, 12'hfff);
    wr(8'hbc, 32'hbf);
    conv(2'h3, 4'h6, 12'hfff);
    rd(8'hb4, 32'h0c);
    rd(8'hb0, 32'h2);
    chk(irq, 1'b0);
    wr(8'hb4, 32'hfffffff7);
    rd(8'hb4, 32'h04);
    wr(8'hb0, 32'h0);
    rd(8'hb0, 32'h0);
    // interrupt: status sticky, masked, then cleared by writing one
    wr(8'hc8, 32'h1);
    rd(8'hcc, 32'h1);
    chk(irq, 1'b1);
    wr(8'hcc, 32'h1);
    rd(8'hcc, 32'h0);
    chk(irq, 1'b0);
    // differential input while the mode is still scan is flagged
    wr(8'hc0, 32'h4);
    rd(8'hcc, 32'h2);
    chk(mode_conflict, 1'b1);
    conv(2'h0, 4'h0, 12'h200);
    wr(8'hcc, 32'h2);
    rd(8'hcc, 32'h0);
    chk(mode_conflict, 1'b0);
    // hardware may set enables after software cleared them
    wr(8'hbc, 32'h0);
    wr(8'hb8, 32'h0);
    @(posedge clk_sys);
    hw_enable_set <= 10'h240;
    @(posedge clk_sys);
    hw_enable_set <= 10'h000;
    rd(8'hbc, 32'h40);
    rd(8'hb8, 32'h2);
    // a reset in mid-run brings enables and control back to zero
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'hbc, 32'h0);
    rd(8'hc0, 32'h0);
    chk(ctrl_pins, 32'h0);
    tally_and_finish();
  end
endmodule : awo_ctrl_tb
`default_nettype wire
